// File: design/mode_sense_responder.sv
`timescale 1ns/1ps
// How it works
// - opcode 1Ah, byte 2 control/page, byte 4 length
// - control 00 returns current parameter set
// - control 01 returns changeable-bit mask
// - control 10 returns factory defaults
// - control 11 returns saved set
// - page code zero rejected with 5/24
// - only listed page codes accepted
// - page 3Fh returns all implemented pages
// - select naming page 04h gets illegal request
// - page length byte gives supported byte count
// - transfer stops at min(allocation, available)
// - header, block descriptor, pages in order
// - header byte 0 counts bytes after it
// - medium zero, write protect clear, descriptor length 8
// - density and block count zero, length 5-7
// - saveable flag set when page has editable fields
// - format page fixed fields
// - format page zone fields from active zone
// - geometry page length, cylinders, heads by variant
// - step rate reported zero
// - write current and precomp cylinders zero
// - landing zone reported zero
module mode_sense_responder
    import mode_sense_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // command in
    input  wire logic        cmd_valid,
    input  wire cdb_s        cmd_cdb,
    output logic             cmd_ready,
    // data in phase stream
    output logic             din_valid,
    output din_beat_s        din_beat,
    input  wire logic        din_ready,
    // completion
    output logic             cmd_done,
    output logic             cmd_check,
    output logic      [3:0]  sense_key,
    output logic      [7:0]  sense_asc
);

    typedef struct packed {
        ctl_state_e  st;
        logic [1:0]  pcs;
        logic [5:0]  page;
        logic [7:0]  idx;
        logic [7:0]  remain;
        logic        out_valid;
        din_beat_s   beat;
        logic        ready;
        logic        done;
        logic        check;
        logic [3:0]  skey;
        logic [7:0]  asc;
        logic [23:0] cur_blk;
        logic [23:0] sav_blk;
        zone_s       zone;
        logic        sel_reject;
        logic [31:0] rdata;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // ------------------------------------------------------------
    // response byte builders
    // ------------------------------------------------------------
    function automatic logic page_known(input logic [5:0] pg);
        page_known = (pg == PG_ERRREC) || (pg == PG_DISCON) ||
                     (pg == PG_FORMAT) || (pg == PG_GEOMETRY) ||
                     (pg == PG_CACHE) || (pg == PG_NOTCH) ||
                     (pg == PG_SHUTDOWN) || (pg == PG_UNIQUE_A) ||
                     (pg == PG_UNIQUE_B) || (pg == PG_ALL);
    endfunction

    // pages other than format and geometry carry no modelled body
    function automatic logic [7:0] page_bytes(input logic [5:0] pg);
        if (pg == PG_FORMAT)
            page_bytes = FMT_BYTES;
        else if (pg == PG_GEOMETRY)
            page_bytes = GEO_BYTES;
        else if (pg == PG_ALL)
            page_bytes = 8'(FMT_BYTES + GEO_BYTES);
        else
            page_bytes = 8'h00;
    endfunction

    // neither page has an initiator-editable field, so not saveable
    function automatic logic [7:0] fmt_byte(input logic [7:0] off,
                                            input logic mask,
                                            input zone_s z);
        logic [7:0] b;
        b = 8'h00;
        case (off)
            8'd0:  b = {2'b00, PG_FORMAT};
            8'd1:  b = FMT_LEN;
            8'd2:  b = TRACKS_PER_ZONE[15:8];
            8'd3:  b = TRACKS_PER_ZONE[7:0];
            8'd5:  b = ALT_PER_ZONE;
            8'd7:  b = ALT_PER_ZONE;
            8'd11: b = z.spt;
            8'd12: b = SECT_SIZE_HI;
            8'd15: b = INTERLEAVE;
            8'd17: b = z.trk_skew;
            8'd19: b = z.cyl_skew;
            8'd20: b = SOFT_SECTOR;
            default: b = 8'h00;
        endcase
        if (mask && off > 8'd1)
            b = 8'h00;
        fmt_byte = b;
    endfunction

    function automatic logic [7:0] geo_byte(input logic [7:0] off,
                                            input logic mask,
                                            input logic four);
        logic [7:0] b;
        b = 8'h00;
        case (off)
            8'd0: b = {2'b00, PG_GEOMETRY};
            8'd1: b = GEO_LEN;
            8'd3: b = CYL_MID;
            8'd4: b = CYL_LOW;
            8'd5: b = four ? HEADS_FOUR : HEADS_TWO;
            default: b = 8'h00;
        endcase
        if (mask && off > 8'd1)
            b = 8'h00;
        geo_byte = b;
    endfunction

    function automatic logic [7:0] resp_byte(input logic [7:0] i,
                                             input logic [5:0] pg,
                                             input logic [7:0] tot,
                                             input logic [23:0] blk,
                                             input logic mask,
                                             input zone_s z);
        logic [7:0] p;
        p = 8'(i - HDR_BYTES - BD_BYTES);
        if (i == 8'd0)
            resp_byte = 8'(tot - 8'd1);
        else if (i == 8'd3)
            resp_byte = BD_BYTES;
        else if (i < HDR_BYTES)
            resp_byte = 8'h00;
        else if (i == 8'd9)
            resp_byte = blk[23:16];
        else if (i == 8'd10)
            resp_byte = blk[15:8];
        else if (i == 8'd11)
            resp_byte = blk[7:0];
        else if (i < 8'(HDR_BYTES + BD_BYTES))
            resp_byte = 8'h00;
        else if (pg == PG_GEOMETRY)
            resp_byte = geo_byte(p, mask, z.heads4);
        else if (p < FMT_BYTES)
            resp_byte = fmt_byte(p, mask, z);
        else
            resp_byte = geo_byte(8'(p - FMT_BYTES), mask, z.heads4);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [7:0]  total_len;
    logic [23:0] sel_blk;
    logic [5:0]  cmd_page;
    logic [1:0]  cmd_pcs;
    logic        slot_free;

    always_comb
    begin
        nxt_st    = st_ff;
        cmd_page  = cmd_cdb.page_byte[5:0];
        cmd_pcs   = cmd_cdb.page_byte[PCS_MSB:PCS_LSB];
        total_len = 8'(HDR_BYTES + BD_BYTES + page_bytes(st_ff.page));
        slot_free = !st_ff.out_valid || din_ready;
        case (st_ff.pcs)
            PCS_CURRENT:    sel_blk = st_ff.cur_blk;
            PCS_CHANGEABLE: sel_blk = BLK_LEN_CHANGE;
            PCS_DEFAULT:    sel_blk = BLK_LEN_DEFAULT;
            default:        sel_blk = st_ff.sav_blk;
        endcase
        nxt_st.done  = 1'b0;
        nxt_st.rdata = 32'h0;

        case (st_ff.st)
            ST_LOAD:
            begin
                nxt_st.cur_blk = st_ff.sav_blk;
                nxt_st.ready   = 1'b1;
                nxt_st.st      = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    nxt_st.ready = 1'b0;
                    nxt_st.pcs   = cmd_pcs;
                    nxt_st.page  = cmd_page;
                    nxt_st.idx   = 8'h00;
                    nxt_st.check = 1'b0;
                    nxt_st.skey  = SK_NONE;
                    nxt_st.asc   = ASC_NONE;
                    if (cmd_cdb.opcode != OPC_MODE_REPORT)
                    begin
                        nxt_st.check = 1'b1;
                        nxt_st.skey  = SK_ILLEGAL;
                        nxt_st.asc   = ASC_BAD_OPCODE;
                        nxt_st.done  = 1'b1;
                        nxt_st.ready = 1'b1;
                    end
                    else if (cmd_page == PG_NONE || !page_known(cmd_page))
                    begin
                        nxt_st.check = 1'b1;
                        nxt_st.skey  = SK_ILLEGAL;
                        nxt_st.asc   = ASC_BAD_FIELD;
                        nxt_st.done  = 1'b1;
                        nxt_st.ready = 1'b1;
                    end
                    else
                    begin
                        nxt_st.remain = cmd_cdb.alloc_len;
                        if (8'(HDR_BYTES + BD_BYTES + page_bytes(cmd_page))
                            < cmd_cdb.alloc_len)
                            nxt_st.remain = 8'(HDR_BYTES + BD_BYTES
                                               + page_bytes(cmd_page));
                        nxt_st.st = ST_SEND;
                    end
                end
            end
            ST_SEND:
            begin
                if (slot_free)
                begin
                    if (st_ff.remain == 8'h00)
                    begin
                        nxt_st.out_valid = 1'b0;
                        nxt_st.done      = 1'b1;
                        nxt_st.ready     = 1'b1;
                        nxt_st.st        = ST_IDLE;
                    end
                    else
                    begin
                        nxt_st.out_valid = 1'b1;
                        nxt_st.beat.data = resp_byte(st_ff.idx, st_ff.page,
                            total_len, sel_blk,
                            st_ff.pcs == PCS_CHANGEABLE, st_ff.zone);
                        nxt_st.beat.last = (st_ff.remain == 8'h01);
                        nxt_st.idx       = 8'(st_ff.idx + 8'h01);
                        nxt_st.remain    = 8'(st_ff.remain - 8'h01);
                    end
                end
            end
            default:
                nxt_st.st = ST_IDLE;
        endcase

        // --------------------------------------------------------
        // register port
        // --------------------------------------------------------
        if (reg_wr)
        begin
            if (reg_addr == REG_SEL_COMMIT)
            begin
                nxt_st.cur_blk = reg_wdata[23:0];
                if (reg_wdata[SEL_SAVE_BIT])
                    nxt_st.sav_blk = reg_wdata[23:0];
            end
            else if (reg_addr == REG_ZONE)
            begin
                nxt_st.zone.spt      = reg_wdata[7:0];
                nxt_st.zone.trk_skew = reg_wdata[15:8];
                nxt_st.zone.cyl_skew = reg_wdata[23:16];
                nxt_st.zone.heads4   = reg_wdata[ZONE_HEADS_BIT];
            end
            else if (reg_addr == REG_STATUS)
            begin
                if (reg_wdata[ST_REJECT_BIT])
                    nxt_st.sel_reject = 1'b0;
            end
        end
        // set placed after clear so a same-cycle event wins
        if (reg_wr && reg_addr == REG_SEL_PAGE &&
            (reg_wdata[5:0] == PG_GEOMETRY || reg_wdata[5:0] == PG_FORMAT
             || reg_wdata[5:0] == PG_ALL))
            nxt_st.sel_reject = 1'b1;

        if (reg_rd)
        begin
            if (reg_addr == REG_ZONE)
                nxt_st.rdata = {7'h00, st_ff.zone.heads4,
                                st_ff.zone.cyl_skew, st_ff.zone.trk_skew,
                                st_ff.zone.spt};
            else if (reg_addr == REG_STATUS)
                nxt_st.rdata = {8'h00, st_ff.asc, 4'h0, st_ff.skey,
                                5'h00, st_ff.check, st_ff.sel_reject,
                                st_ff.st != ST_IDLE};
            else if (reg_addr == REG_CUR_BLK)
                nxt_st.rdata = {8'h00, st_ff.cur_blk};
            else if (reg_addr == REG_SAV_BLK)
                nxt_st.rdata = {8'h00, st_ff.sav_blk};
            else
                nxt_st.rdata = 32'h0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff             <= '0;
            st_ff.st          <= ST_LOAD;
            st_ff.cur_blk     <= BLK_LEN_DEFAULT;
            st_ff.sav_blk     <= BLK_LEN_DEFAULT;
            st_ff.zone.spt      <= ZONE_SPT_RST;
            st_ff.zone.trk_skew <= ZONE_SKEW_RST;
            st_ff.zone.cyl_skew <= ZONE_SKEW_RST;
            st_ff.zone.heads4   <= HEADS4_RST;
        end
        else if (clk_en)
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign cmd_ready = st_ff.ready;
    assign din_valid = st_ff.out_valid;
    assign din_beat  = st_ff.beat;
    assign cmd_done  = st_ff.done;
    assign cmd_check = st_ff.check;
    assign sense_key = st_ff.skey;
    assign sense_asc = st_ff.asc;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_zero_page_reject: assert property (
        clk_en && st_ff.st == ST_IDLE && cmd_valid &&
        cmd_cdb.opcode == OPC_MODE_REPORT && cmd_cdb.page_byte[5:0] == 6'h00
        |=> cmd_check && sense_key == 4'h5 && sense_asc == 8'h24
            && !din_valid)
        else $error("page zero not rejected with 5/24");

    a_zero_alloc: assert property (
        clk_en && st_ff.st == ST_IDLE && cmd_valid &&
        cmd_cdb.opcode == OPC_MODE_REPORT && cmd_cdb.alloc_len == 8'h00
        && page_known(cmd_cdb.page_byte[5:0])
        |=> !din_valid ##1 !din_valid)
        else $error("data sent with zero allocation");

    a_header_len: assert property (
        din_valid && st_ff.idx == 8'd1 && $changed(st_ff.idx)
        |-> din_beat.data == 8'(total_len - 8'd1))
        else $error("header length byte wrong");

    a_desc_len: assert property (
        din_valid && st_ff.idx == 8'd4 && $changed(st_ff.idx)
        |-> din_beat.data == 8'h08)
        else $error("descriptor length not eight");

    a_geo_heads: assert property (
        din_valid && $changed(st_ff.idx) && st_ff.page == PG_GEOMETRY
        && st_ff.idx == 8'd18 && st_ff.pcs != PCS_CHANGEABLE
        |-> din_beat.data == (st_ff.zone.heads4 ? 8'h04 : 8'h02))
        else $error("head count wrong");

    a_fmt_length: assert property (
        din_valid && $changed(st_ff.idx) && st_ff.page == PG_FORMAT
        && st_ff.idx == 8'd14
        |-> din_beat.data == 8'h16)
        else $error("format page length wrong");

    a_reload_saved: assert property (
        $past(st_ff.st) == ST_LOAD && st_ff.st == ST_IDLE
        |-> st_ff.cur_blk == st_ff.sav_blk && cmd_ready)
        else $error("current set not reloaded");

    a_select_geo: assert property (
        clk_en && reg_wr && reg_addr == REG_SEL_PAGE
        && reg_wdata[5:0] == 6'h04
        |=> st_ff.sel_reject)
        else $error("geometry select not refused");

    a_last_ends: assert property (
        clk_en && din_valid && din_ready && din_beat.last
        |=> !din_valid && cmd_done)
        else $error("transfer did not end after last byte");

endmodule

// File: design/mode_sense_pkg.sv
package mode_sense_pkg;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_MODE_REPORT = 8'h1a;
    localparam int         PCS_MSB         = 7;
    localparam int         PCS_LSB         = 6;
    localparam logic [1:0] PCS_CURRENT     = 2'h0;
    localparam logic [1:0] PCS_CHANGEABLE  = 2'h1;
    localparam logic [1:0] PCS_DEFAULT     = 2'h2;
    localparam logic [1:0] PCS_SAVED       = 2'h3;
    localparam logic [5:0] PG_NONE         = 6'h00;
    localparam logic [5:0] PG_ERRREC       = 6'h01;
    localparam logic [5:0] PG_DISCON       = 6'h02;
    localparam logic [5:0] PG_FORMAT       = 6'h03;
    localparam logic [5:0] PG_GEOMETRY     = 6'h04;
    localparam logic [5:0] PG_CACHE        = 6'h08;
    localparam logic [5:0] PG_NOTCH        = 6'h0c;
    localparam logic [5:0] PG_SHUTDOWN     = 6'h32;
    localparam logic [5:0] PG_UNIQUE_A     = 6'h37;
    localparam logic [5:0] PG_UNIQUE_B     = 6'h39;
    localparam logic [5:0] PG_ALL          = 6'h3f;

    // ------------------------------------------------------------
    // sense codes
    // ------------------------------------------------------------
    localparam logic [3:0] SK_NONE         = 4'h0;
    localparam logic [3:0] SK_ILLEGAL      = 4'h5;
    localparam logic [7:0] ASC_NONE        = 8'h00;
    localparam logic [7:0] ASC_BAD_OPCODE  = 8'h20;
    localparam logic [7:0] ASC_BAD_FIELD   = 8'h24;

    // ------------------------------------------------------------
    // response layout
    // ------------------------------------------------------------
    localparam logic [7:0] HDR_BYTES       = 8'h04;
    localparam logic [7:0] BD_BYTES        = 8'h08;
    localparam logic [7:0] FMT_LEN         = 8'h16;
    localparam logic [7:0] GEO_LEN         = 8'h12;
    localparam logic [7:0] FMT_BYTES       = 8'h18;
    localparam logic [7:0] GEO_BYTES       = 8'h14;
    localparam logic [7:0] SECT_SIZE_HI    = 8'h02;
    localparam logic [7:0] ALT_PER_ZONE    = 8'h01;
    localparam logic [7:0] INTERLEAVE      = 8'h01;
    localparam logic [7:0] SOFT_SECTOR     = 8'h80;
    localparam logic [7:0] CYL_MID         = 8'h0b;
    localparam logic [7:0] CYL_LOW         = 8'h25;
    localparam logic [7:0] HEADS_FOUR      = 8'h04;
    localparam logic [7:0] HEADS_TWO       = 8'h02;
    localparam logic [15:0] TRACKS_PER_ZONE = 16'h0000;
    localparam logic [23:0] BLK_LEN_DEFAULT = 24'h000200;
    localparam logic [23:0] BLK_LEN_CHANGE  = 24'hffffff;
    localparam int          STEP_RATE_NS    = 100;

    // ------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] REG_SEL_COMMIT  = 8'h00;
    localparam logic [7:0] REG_SEL_PAGE    = 8'h04;
    localparam logic [7:0] REG_ZONE        = 8'h08;
    localparam logic [7:0] REG_STATUS      = 8'h0c;
    localparam logic [7:0] REG_CUR_BLK     = 8'h10;
    localparam logic [7:0] REG_SAV_BLK     = 8'h14;
    localparam int         SEL_SAVE_BIT    = 24;
    localparam int         ZONE_HEADS_BIT  = 24;
    localparam int         ST_REJECT_BIT   = 1;
    localparam logic [7:0] ZONE_SPT_RST    = 8'h00;
    localparam logic [7:0] ZONE_SKEW_RST   = 8'h00;
    localparam logic       HEADS4_RST      = 1'b1;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } ctl_state_e;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] page_byte;
        logic [7:0] alloc_len;
    } cdb_s;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } din_beat_s;

    typedef struct packed {
        logic [7:0] spt;
        logic [7:0] trk_skew;
        logic [7:0] cyl_skew;
        logic       heads4;
    } zone_s;

endpackage

// File: test/scsi_host_model.sv
`timescale 1ns/1ps
module scsi_host_model
    import mode_sense_pkg::*;
(
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      sys_rst,
    // data in phase
    input  wire logic      din_valid,
    input  wire din_beat_s din_beat,
    output logic           din_ready,
    // pacing
    input  wire logic      stall
);
    // ------------------------------------------------------------
    // byte sink
    // ------------------------------------------------------------
    logic [7:0] rx [$];
    int         last_at;
    logic [1:0] pace_ff;

    // one refused cycle in four makes the sender hold its byte
    assign din_ready = !(stall && pace_ff == 2'h3);

    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
            pace_ff <= 2'h0;
        else
            pace_ff <= pace_ff + 2'h1;

    always @(posedge core_clk)
        if (din_valid && din_ready)
        begin
            rx.push_back(din_beat.data);
            if (din_beat.last)
                last_at = rx.size();
        end
endmodule

// File: test/test_mode_sense_responder.sv
`timescale 1ns/1ps
module test_mode_sense_responder
    import mode_sense_pkg::*;
;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    logic        core_clk, sys_rst, clk_en, reg_wr, reg_rd, stall;
    logic        cmd_valid, cmd_ready, din_valid, din_ready;
    logic        cmd_done, cmd_check;
    logic [3:0]  sense_key;
    logic [7:0]  reg_addr, sense_asc, spt, trk, cyl, hd;
    logic [31:0] reg_wdata, reg_rdata;
    logic [23:0] cur_blk, sav_blk;
    logic [7:0]  ex [64];
    logic [7:0]  okpg [7] = '{8'h01, 8'h02, 8'h08, 8'h0c, 8'h32, 8'h37, 8'h39};
    logic [7:0]  badpg [3] = '{8'h00, 8'h38, 8'h3e};
    cdb_s        cmd_cdb;
    din_beat_s   din_beat;
    int          num_errors, check_count, cycles, n;

    mode_sense_responder i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
        .cmd_cdb(cmd_cdb), .cmd_ready(cmd_ready), .din_valid(din_valid),
        .din_beat(din_beat), .din_ready(din_ready), .cmd_done(cmd_done),
        .cmd_check(cmd_check), .sense_key(sense_key), .sense_asc(sense_asc)
    );
    scsi_host_model i_host (
        .core_clk(core_clk), .sys_rst(sys_rst), .din_valid(din_valid),
        .din_beat(din_beat), .din_ready(din_ready), .stall(stall)
    );

    always #5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("reg", reg_rdata & m, e);
        @(posedge core_clk);
    endtask

    task automatic put(input logic [191:0] v, input int len);
        for (int i = 0; i < len; i++)
            ex[n+i] = v[191-8*i -: 8];
        n += len;
    endtask

    // expected response image for one page byte
    task automatic build(input logic [7:0] pb);
        logic m;
        m = (pb[7:6] == 2'h1);
        n = 12;
        for (int i = 0; i < 64; i++)
            ex[i] = 8'h00;
        if (pb[5:0] == 6'h03 || pb[5:0] == 6'h3f)
            put(m ? {16'h0316, 176'h0} : {16'h0316, 48'h000000010001, 24'h0,
                spt, 40'h0200000100, trk, 8'h00, cyl, 32'h80000000}, 24);
        if (pb[5:0] == 6'h04 || pb[5:0] == 6'h3f)
            put(m ? {16'h0412, 176'h0}
                : {16'h0412, 24'h000b25, hd, 144'h0}, 20);
        ex[0] = 8'(n - 1);
        ex[3] = 8'h08;
        {ex[9], ex[10], ex[11]} = m ? 24'hffffff : pb[7:6] == 2'h0 ? cur_blk
            : pb[7:6] == 2'h3 ? sav_blk : 24'h000200;
    endtask

    task automatic cmd(input logic [7:0] op, pb, al, asc);
        int b, w;
        b = i_host.rx.size();
        build(pb);
        w = asc != 8'h00 ? 0 : al < n ? al : n;
        while (cmd_ready !== 1'b1)
            @(posedge core_clk);
        cmd_cdb   <= {op, pb, al};
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        #1;
        while (cmd_done !== 1'b1)
            @(posedge core_clk) #1;
        chk("ready", cmd_ready, 1'b1);
        chk("check", cmd_check, asc != 8'h00);
        chk("key", sense_key, asc != 8'h00 ? 4'h5 : 4'h0);
        chk("asc", sense_asc, asc);
        chk("count", i_host.rx.size() - b, w);
        for (int i = 0; i < w; i++)
            chk("byte", i_host.rx[b+i], ex[i]);
        if (w > 0)
            chk("last", i_host.last_at, b + w);
        @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        sys_rst  = 1'b1;
        clk_en   = 1'b1;
        {reg_wr, reg_rd, cmd_valid, stall} = 4'h0;
        {reg_addr, reg_wdata, cmd_cdb} = '0;
        {num_errors, check_count, cycles} = '0;
        {cur_blk, sav_blk} = {2{24'h000200}};
        {spt, trk, cyl, hd} = 32'h00000004;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(REG_CUR_BLK, '1, 32'h200);
        rd(REG_SAV_BLK, '1, 32'h200);
        rd(8'hf0, '1, 32'h0);
        cmd(8'h1a, 8'h3f, 8'hff, 8'h00);
        foreach (okpg[i])
            cmd(8'h1a, okpg[i], 8'hff, 8'h00);
        foreach (badpg[i])
            cmd(8'h1a, badpg[i], 8'hff, 8'h24);
        cmd(8'h15, 8'h03, 8'hff, 8'h20);
        cmd(8'h1a, 8'h03, 8'h00, 8'h00);
        cmd(8'h1a, 8'h03, 8'h05, 8'h00);
        cmd(8'h1a, 8'h04, 8'h20, 8'h00);
        wr(REG_ZONE, 32'h000a053f);
        {spt, trk, cyl, hd} = 32'h3f050a02;
        wr(REG_SEL_COMMIT, 32'h00000400);
        cur_blk = 24'h000400;
        rd(REG_CUR_BLK, '1, 32'h400);
        rd(REG_SAV_BLK, '1, 32'h200);
        stall <= 1'b1;
        for (int p = 0; p < 4; p++)
            cmd(8'h1a, {p[1:0], 6'h3f}, 8'hff, 8'h00);
        stall <= 1'b0;
        wr(REG_SEL_COMMIT, 32'h01000800);
        {cur_blk, sav_blk} = {2{24'h000800}};
        for (int p = 0; p < 4; p++)
            cmd(8'h1a, {p[1:0], 6'h04}, 8'hff, 8'h00);
        wr(REG_SEL_PAGE, 32'h01);
        rd(REG_STATUS, 32'h2, 32'h0);
        wr(REG_SEL_PAGE, 32'h04);
        rd(REG_STATUS, 32'h2, 32'h2);
        wr(REG_STATUS, 32'h2);
        rd(REG_STATUS, 32'h2, 32'h0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        {cur_blk, sav_blk} = {2{24'h000200}};
        {spt, trk, cyl, hd} = 32'h00000004;
        repeat (2) @(posedge core_clk);
        cmd(8'h1a, 8'h3f, 8'hff, 8'h00);
        close_out();
    end
endmodule
